// ===== bench/plsc_plant.sv
`timescale 1ns/1ps
// ==================================================
// Process transducer: jumps to its target, or creeps in steps when slow
module plsc_plant (
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic [15:0] i_target,
  output logic      [15:0] o_feedback
);
  logic [15:0] level;
  logic [15:0] next_level;

  // Slow creep lets the rate-of-change term see a ramped error
  always_comb begin
    next_level = i_target;
    if (i_slow && level + 16'h0100 < i_target) begin
      next_level = level + 16'h0100;
    end
    if (i_slow && level > i_target + 16'h0100) begin
      next_level = level - 16'h0100;
    end
  end

  always_ff @(posedge i_clk) begin
    level <= next_level;
  end

  assign o_feedback = level;
endmodule

// ===== bench/plsc_top_sva.sv
`timescale 1ns/1ps
// ==================================================
// Port checker for the loop speed controller
module plsc_top_sva #(
  parameter int W = 16
) (
  input wire logic         i_clk,
  input wire logic         i_rst_n,
  input wire logic         i_rd,
  input wire logic         i_auto_mode,
  input wire logic         i_key_enter,
  input wire logic [15:0]  i_out_freq,
  input wire logic [31:0]  o_rdata,
  input wire logic [W-1:0] o_speed_cmd,
  input wire logic         o_loop_active,
  input wire logic         o_status_is_freq,
  input wire logic [15:0]  o_status_value,
  input wire logic [1:0]   o_disp_field,
  input wire logic         o_disp_flash_label,
  input wire logic [15:0]  o_disp_value
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_enter_on_load;
    $rose(i_key_enter) && o_status_is_freq && o_disp_field == 2'h0 && !o_disp_flash_label;
  endsequence
  sequence s_label_run;
    o_disp_flash_label [*4];
  endsequence

  // Reset itself must not be masked here
  property p_reset_clear;
    disable iff (1'b0) !i_rst_n |=> o_speed_cmd == '0 && o_rdata == 32'h0;
  endproperty
  property p_rdata_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  property p_manual_inactive;
    !i_auto_mode |=> !o_loop_active;
  endproperty
  property p_speed_idle;
    !o_loop_active [*3] |-> o_speed_cmd == '0;
  endproperty
  property p_status_freq;
    o_status_is_freq |-> o_status_value == $past(i_out_freq);
  endproperty
  property p_enter_steps;
    s_enter_on_load |-> ##[1:8] o_disp_field == 2'h1;
  endproperty
  property p_label_hides;
    o_disp_flash_label |-> o_disp_field == 2'h2 && o_disp_value == 16'h0000;
  endproperty
  property p_label_length;
    $rose(o_disp_flash_label) |-> s_label_run ##[1:12] !o_disp_flash_label;
  endproperty

  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared in reset");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  a_manual_inactive: assert property (p_manual_inactive) else $error("loop active in manual");
  a_speed_idle: assert property (p_speed_idle) else $error("speed while loop idle");
  a_status_freq: assert property (p_status_freq) else $error("status not frequency");
  a_enter_steps: assert property (p_enter_steps) else $error("enter did not step field");
  a_label_hides: assert property (p_label_hides) else $error("label shows a value");
  a_label_length: assert property (p_label_length) else $error("label flash length");
endmodule

bind plsc_top plsc_top_sva #(.W(W)) plsc_top_sva_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(i_rd), .i_auto_mode(i_auto_mode),
  .i_key_enter(i_key_enter), .i_out_freq(i_out_freq), .o_rdata(o_rdata),
  .o_speed_cmd(o_speed_cmd), .o_loop_active(o_loop_active),
  .o_status_is_freq(o_status_is_freq), .o_status_value(o_status_value),
  .o_disp_field(o_disp_field), .o_disp_flash_label(o_disp_flash_label),
  .o_disp_value(o_disp_value)
);

// ===== bench/plsc_top_tb.sv
`timescale 1ns/1ps
// ==================================================
// Bench for the loop speed controller
module plsc_top_tb;
  logic        i_clk, i_rst_n, i_wr, i_rd, i_auto_mode, i_normal_display, slow, seen, ce;
  logic        i_key_up, i_key_down, i_key_enter, o_loop_active, o_status_is_freq, o_flash;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [2:0]  i_sel;
  logic [15:0] cur, fb_tgt, fb, freq, o_speed_cmd, o_status_value, o_disp_value;
  logic [1:0]  o_disp_field;
  logic [31:0] src_exp [8] = '{32'h0444, 32'h8000, 32'h0, 32'h0, 32'h1111, 32'h2222,
                               32'h3333, 32'h1111};
  int          errors, n_tests;

  plsc_top #(.SAMPLE_CYCLES(16), .TENTH_CYCLES(65535), .FLASH_CYCLES(8)) plsc_top_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_auto_mode(i_auto_mode),
    .i_normal_display(i_normal_display), .i_voltage_input_terminal(fb),
    .i_current_loop_input_terminal(cur), .i_source_select_terminals(i_sel),
    .i_key_up(i_key_up), .i_key_down(i_key_down), .i_key_enter(i_key_enter),
    .i_out_freq(freq), .i_load_pct(16'h0039), .i_motor_volts(16'h0155),
    .o_speed_cmd(o_speed_cmd), .o_loop_active(o_loop_active),
    .o_status_is_freq(o_status_is_freq), .o_status_value(o_status_value),
    .o_disp_field(o_disp_field), .o_disp_flash_label(o_flash), .o_disp_value(o_disp_value));
  plsc_plant plsc_plant_inst (.i_clk(i_clk), .i_slow(slow), .i_target(fb_tgt), .o_feedback(fb));

  // ==================================================
  // Clock, bus and check tasks
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk) begin
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
    end
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk) begin
      i_addr <= a;
      i_rd <= 1'b1;
    end
    @(posedge i_clk) i_rd <= 1'b0;
    @(posedge i_clk) v = o_rdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  task key(input logic [2:0] k);
    @(posedge i_clk) {i_key_enter, i_key_down, i_key_up} <= k;
    wt(6);
    {i_key_enter, i_key_down, i_key_up} <= 3'h0;
    wt(6);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    wt(20000);
    errors++;
    test_done;
  end

  // ==================================================
  // Tests
  initial begin
    {i_rst_n, i_wr, i_rd, i_key_up, i_key_down, i_key_enter, slow} = 7'h0;
    {i_auto_mode, i_normal_display, ce} = 3'h7;
    {i_addr, i_wdata, i_sel} = '0;
    {cur, fb_tgt, freq} = {16'h8000, 16'h4000, 16'h1234};
    wt(12);
    i_rst_n <= 1'b1;
    wt(4);
    rc(8'h04, 32'h1);
    rc(8'h14, 32'h100);
    rc(8'h00, 32'h0);
    wr(8'h3C, 32'h5);
    rc(8'h3C, 32'h0);
    wr(8'h08, 32'h1111);
    wr(8'h0C, 32'h2222);
    wr(8'h10, 32'h3333);
    wr(8'h24, 32'h0444);
    i_sel <= 3'h4;
    for (int s = 0; s < 8; s++) begin
      wr(8'h04, 32'(s));
      wt(10);
      rc(8'h30, src_exp[s]);
      if (s == 2) rc(8'h28, 32'h2);
    end
    i_sel <= 3'h5;
    wt(10);
    rc(8'h30, 32'h2222);
    wr(8'h04, 32'h0);
    key(3'h1);
    rc(8'h24, 32'h0484);
    key(3'h2);
    key(3'h2);
    rc(8'h24, 32'h0404);
    i_normal_display <= 1'b0;
    key(3'h1);
    rc(8'h24, 32'h0404);
    i_normal_display <= 1'b1;
    // Gain 1.0, feedback on the voltage input, setpoint from the current loop
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h1);
    wt(40);
    chk(32'(o_speed_cmd), 32'h4000);
    chk(32'(o_loop_active), 32'h1);
    rc(8'h28, 32'h1);
    fb_tgt <= 16'h6000;
    wt(40);
    chk(32'(o_speed_cmd), 32'h2000);
    chk(32'(o_status_is_freq), 32'h1);
    chk(32'(o_status_value), 32'h1234);
    freq <= 16'h0BCD;
    wr(8'h00, 32'h3);
    wt(40);
    chk(32'(o_speed_cmd), 32'h0);
    chk(32'(o_status_value), 32'h0BCD);
    slow <= 1'b1;
    fb_tgt <= 16'hA000;
    wt(120);
    chk(32'(o_speed_cmd), 32'h2000);
    chk(32'(o_disp_value), 32'h0039);
    key(3'h4);
    chk(32'(o_disp_value), 32'h0155);
    @(posedge i_clk) i_key_enter <= 1'b1;
    wt(6);
    chk(32'({o_flash, o_disp_field}), 32'h6);
    wt(20);
    i_key_enter <= 1'b0;
    chk(32'({o_flash, o_disp_field, o_disp_value}), 32'h2A000);
    key(3'h4);
    chk(32'(o_disp_field), 32'h0);
    // Integral alone: 0x2000 error adds exactly 0x20 per sample tick
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h100);
    wr(8'h00, 32'h3);
    wt(40);
    d = 32'(o_speed_cmd);
    wt(64);
    chk(32'(o_speed_cmd), d + 32'h80);
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h1C, 32'h100);
    wr(8'h00, 32'h3);
    wt(40);
    chk(32'(o_speed_cmd), 32'h0);
    seen = 1'b0;
    fb_tgt <= 16'hB000;
    repeat (60) begin
      wt(1);
      if (o_speed_cmd !== 16'h0) seen = 1'b1;
    end
    chk(32'(seen), 32'h1);
    wt(40);
    chk(32'(o_speed_cmd), 32'h0);
    // Two tenths over full scale: one LSB every second clock with this tenth
    wr(8'h20, 32'h2);
    cur <= 16'h8400;
    wt(1000);
    rd(8'h30, d);
    chk(32'(d > 32'h8000 && d < 32'h8400), 32'h1);
    wt(1200);
    rc(8'h30, 32'h8400);
    i_auto_mode <= 1'b0;
    wt(5);
    chk(32'({o_loop_active, o_speed_cmd}), 32'h0);
    test_done;
  end
endmodule

// ===== include/plsc_defs.svh
`ifndef PLSC_DEFS_SVH
`define PLSC_DEFS_SVH

// ==================================================
// Register offsets (byte addresses)
`define PLSC_OFS_CTRL      8'h00
`define PLSC_OFS_SOURCE    8'h04
`define PLSC_OFS_PRESET1   8'h08
`define PLSC_OFS_PRESET2   8'h0C
`define PLSC_OFS_PRESET4   8'h10
`define PLSC_OFS_KP        8'h14
`define PLSC_OFS_KI        8'h18
`define PLSC_OFS_KD        8'h1C
`define PLSC_OFS_RAMP      8'h20
`define PLSC_OFS_KEYPAD_SP 8'h24
`define PLSC_OFS_STATUS    8'h28
`define PLSC_OFS_SPEED     8'h2C
`define PLSC_OFS_SETPOINT  8'h30
`define PLSC_OFS_FEEDBACK  8'h34

// ==================================================
// Field positions
`define PLSC_CTRL_LOOP_EN    0
`define PLSC_CTRL_REVERSE    1
`define PLSC_CTRL_FB_CURRENT 2
`define PLSC_STAT_ACTIVE     0
`define PLSC_STAT_CONFLICT   1

// ==================================================
// Reset values and keypad step size
`define PLSC_RST_CTRL   3'h0
`define PLSC_RST_SOURCE 3'h1
`define PLSC_RST_PRESET 16'h0000
`define PLSC_RST_KP     16'h0100
`define PLSC_RST_KI     16'h0000
`define PLSC_RST_KD     16'h0000
`define PLSC_RST_RAMP   16'h0000
`define PLSC_RST_KSP    16'h0000
`define PLSC_KEY_STEP   16'h0040

// ==================================================
// Timing
`define PLSC_CLK_PERIOD_NS    50
`define PLSC_SAMPLE_PERIOD_NS 3906250
`define PLSC_TENTH_S_NS       100000000
`define PLSC_FLASH_NS         1000000000
`define PLSC_SAMPLE_CYC (`PLSC_SAMPLE_PERIOD_NS / `PLSC_CLK_PERIOD_NS)
`define PLSC_TENTH_CYC  (`PLSC_TENTH_S_NS / `PLSC_CLK_PERIOD_NS)
`define PLSC_FLASH_CYC  (`PLSC_FLASH_NS / `PLSC_CLK_PERIOD_NS)

`endif

// ===== include/plsc_pkg.sv
package plsc_pkg;

  typedef enum logic [2:0] {
    PLSC_SRC_KEYPAD,
    PLSC_SRC_CURRENT,
    PLSC_SRC_VOLTAGE,
    PLSC_SRC_POT,
    PLSC_SRC_PRESET1,
    PLSC_SRC_PRESET2,
    PLSC_SRC_PRESET4,
    PLSC_SRC_SELECTED
  } plsc_src_t;

  typedef enum logic [1:0] {
    PLSC_DISP_LOAD,
    PLSC_DISP_VOLTS,
    PLSC_DISP_FEEDBACK
  } plsc_disp_t;

endpackage

// ===== rtl/plsc_ramp.sv
`timescale 1ns/1ps
`include "plsc_defs.svh"

module plsc_ramp #(
  parameter int W             = 16,
  parameter int CYC_PER_TENTH = `PLSC_TENTH_CYC
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_target,
  input  wire logic [15:0]  i_ramp_time,
  output logic      [W-1:0] o_value
);

  // ==================================================
  // Parameter check: at most one LSB per clock, so a tenth must span full scale
  if (CYC_PER_TENTH < (1 << W) - 1) begin : g_bad_rate
    $error("plsc_ramp: CYC_PER_TENTH below full scale");
  end

  // ==================================================
  // Phase accumulator: one LSB step each time full scale worth of credit
  // reaches or exceeds the ramp time in clocks, so no divider is needed
  localparam logic [39:0] FULL  = 40'((1 << W) - 1);
  localparam logic [39:0] TENTH = 40'(CYC_PER_TENTH);

  logic [39:0]  acc;
  logic [39:0]  next_acc;
  logic [W-1:0] next_value;
  logic [39:0]  limit;

  always_comb begin
    limit      = 40'(i_ramp_time) * TENTH;
    next_acc   = acc;
    next_value = o_value;
    if (i_ramp_time == 16'h0000) begin
      next_value = i_target;
      next_acc   = 40'h0;
    end else if (o_value == i_target) begin
      next_acc = 40'h0;
    end else if (acc + FULL >= limit) begin
      next_acc = acc + FULL - limit;
      if (o_value < i_target) begin
        next_value = o_value + W'(1);
      end else begin
        next_value = o_value - W'(1);
      end
    end else begin
      next_acc = acc + FULL;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc     <= 40'h0;
      o_value <= '0;
    end else if (i_ce) begin
      acc     <= next_acc;
      o_value <= next_value;
    end
  end

endmodule

// ===== rtl/plsc_top.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "plsc_defs.svh"

// Notes on behaviour
// - Direct acting: falling feedback raises speed, rising feedback lowers it.
// - Reverse acting inverts the error sign, so rising feedback raises speed.
// - Setpoint comes from keypad, current, voltage, pot or presets one, two, four.
// - Selected source choice reads the source select terminals to pick the setpoint.
// - After reset the source selector points at the current loop input.
// - An analog input used for feedback is never taken as setpoint as well.
// - Keypad source: up and down keys step the setpoint on the normal display.
// - Integral term keeps accumulating error so steady-state error goes to zero.
// - Differential term follows rate of change of error, scaled by its gain.
// - Setpoint into the loop ramps from old to new value at the ramp time.
// - Ramp time zero passes the new setpoint straight through.
// - In loop mode the status field shows output frequency, not run.
// - Enter steps the lower-left field through load, voltage and feedback.
// - Selecting the feedback field first flashes a label, then shows the value.
// - Proportional term equals proportional gain times error.
// - Integral term rises at integral gain times error per second.
// - Loop acts only while enabled and the drive is in automatic mode.

module plsc_top #(
  parameter int W             = 16,
  parameter int SAMPLE_CYCLES = `PLSC_SAMPLE_CYC,
  parameter int TENTH_CYCLES  = `PLSC_TENTH_CYC,
  parameter int FLASH_CYCLES  = `PLSC_FLASH_CYC
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [7:0]   i_addr,
  input  wire logic [31:0]  i_wdata,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic      [31:0]  o_rdata,
  input  wire logic         i_auto_mode,
  input  wire logic         i_normal_display,
  input  wire logic [W-1:0] i_voltage_input_terminal,
  input  wire logic [W-1:0] i_current_loop_input_terminal,
  input  wire logic [2:0]   i_source_select_terminals,
  input  wire logic         i_key_up,
  input  wire logic         i_key_down,
  input  wire logic         i_key_enter,
  input  wire logic [15:0]  i_out_freq,
  input  wire logic [15:0]  i_load_pct,
  input  wire logic [15:0]  i_motor_volts,
  output logic      [W-1:0] o_speed_cmd,
  output logic              o_loop_active,
  output logic              o_status_is_freq,
  output logic      [15:0]  o_status_value,
  output logic      [1:0]   o_disp_field,
  output logic              o_disp_flash_label,
  output logic      [15:0]  o_disp_value
);

  // ==================================================
  // Parameter check
  if (W < 8 || W > 16) begin : g_bad_w
    $error("plsc_top: W must lie in 8..16");
  end
  if (SAMPLE_CYCLES < 2 || TENTH_CYCLES < 1 || FLASH_CYCLES < 1) begin : g_bad_cnt
    $error("plsc_top: counts too small");
  end

  localparam int          SW   = 40;
  localparam int          PW   = 2 * W + 6;
  localparam logic [W-1:0] FULL = W'((1 << W) - 1);
  localparam logic signed [SW-1:0] ACC_LIM = SW'(FULL) <<< 16;

  // ==================================================
  // Pin synchronisers: sync1 feeds only sync2
  localparam int PINW = 2 * W + 6;
  logic [PINW-1:0] pin_raw;
  logic [PINW-1:0] sync1;
  logic [PINW-1:0] sync2;
  logic [2:0]      keys_prev;

  assign pin_raw = {i_voltage_input_terminal, i_current_loop_input_terminal,
                    i_source_select_terminals, i_key_up, i_key_down, i_key_enter};

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1     <= '0;
      sync2     <= '0;
      keys_prev <= 3'h0;
    end else if (i_ce) begin
      sync1     <= pin_raw;
      sync2     <= sync1;
      keys_prev <= sync2[2:0];
    end
  end

  logic [W-1:0] volt_in;
  logic [W-1:0] curr_in;
  logic [2:0]   sel_in;
  logic         up_press;
  logic         down_press;
  logic         enter_press;

  assign volt_in     = sync2[PINW-1 -: W];
  assign curr_in     = sync2[W+5 -: W];
  assign sel_in      = sync2[5:3];
  assign up_press    = sync2[2] & ~keys_prev[2];
  assign down_press  = sync2[1] & ~keys_prev[1];
  assign enter_press = sync2[0] & ~keys_prev[0];

  // ==================================================
  // Register file
  logic [2:0]   ctrl;
  logic [2:0]   src_reg;
  logic [15:0]  preset1, preset2, preset4, kp, ki, kd, ramp_time;
  logic [W-1:0] key_sp;
  logic [2:0]   next_ctrl;
  logic [2:0]   next_src;
  logic [15:0]  next_p1, next_p2, next_p4, next_kp, next_ki, next_kd, next_ramp;
  logic [W-1:0] next_key_sp;
  logic [31:0]  next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Setpoint selection
  plsc_pkg::plsc_src_t eff_src;
  logic [W-1:0]        sp_raw;
  logic                conflict;
  logic [W-1:0]        sp_target;
  logic [W-1:0]        sp_ramped;
  logic [W-1:0]        fb_val;
  logic                loop_en;

  assign loop_en = ctrl[`PLSC_CTRL_LOOP_EN] & i_auto_mode;
  assign fb_val  = ctrl[`PLSC_CTRL_FB_CURRENT] ? curr_in : volt_in;

  always_comb begin
    if (plsc_pkg::plsc_src_t'(src_reg) == plsc_pkg::PLSC_SRC_SELECTED) begin
      eff_src = plsc_pkg::plsc_src_t'(sel_in);
      if (eff_src == plsc_pkg::PLSC_SRC_SELECTED) begin
        eff_src = plsc_pkg::PLSC_SRC_KEYPAD;
      end
    end else begin
      eff_src = plsc_pkg::plsc_src_t'(src_reg);
    end
    conflict = 1'b0;
    case (eff_src)
      plsc_pkg::PLSC_SRC_KEYPAD:  sp_raw = key_sp;
      plsc_pkg::PLSC_SRC_CURRENT: begin
        sp_raw   = curr_in;
        conflict = ctrl[`PLSC_CTRL_FB_CURRENT];
      end
      plsc_pkg::PLSC_SRC_VOLTAGE, plsc_pkg::PLSC_SRC_POT: begin
        sp_raw   = volt_in;
        conflict = ~ctrl[`PLSC_CTRL_FB_CURRENT];
      end
      plsc_pkg::PLSC_SRC_PRESET1: sp_raw = preset1[W-1:0];
      plsc_pkg::PLSC_SRC_PRESET2: sp_raw = preset2[W-1:0];
      plsc_pkg::PLSC_SRC_PRESET4: sp_raw = preset4[W-1:0];
      default:                    sp_raw = key_sp;
    endcase
  end

  // Shared input terminal: setpoint falls back to zero rather than chase feedback
  assign sp_target = conflict ? '0 : sp_raw;

  always_comb begin
    next_ctrl   = ctrl;
    next_src    = src_reg;
    next_p1     = preset1;
    next_p2     = preset2;
    next_p4     = preset4;
    next_kp     = kp;
    next_ki     = ki;
    next_kd     = kd;
    next_ramp   = ramp_time;
    next_key_sp = key_sp;
    if (i_wr) begin
      if (hit(i_addr, `PLSC_OFS_CTRL))      next_ctrl   = i_wdata[2:0];
      if (hit(i_addr, `PLSC_OFS_SOURCE))    next_src    = i_wdata[2:0];
      if (hit(i_addr, `PLSC_OFS_PRESET1))   next_p1     = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_PRESET2))   next_p2     = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_PRESET4))   next_p4     = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_KP))        next_kp     = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_KI))        next_ki     = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_KD))        next_kd     = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_RAMP))      next_ramp   = i_wdata[15:0];
      if (hit(i_addr, `PLSC_OFS_KEYPAD_SP)) next_key_sp = i_wdata[W-1:0];
    end
    // Keys act after a same-cycle software write, keeping the press
    if (eff_src == plsc_pkg::PLSC_SRC_KEYPAD && i_normal_display) begin
      if (up_press && !down_press) begin
        next_key_sp = (next_key_sp > FULL - W'(`PLSC_KEY_STEP)) ? FULL
                    : next_key_sp + W'(`PLSC_KEY_STEP);
      end else if (down_press && !up_press) begin
        next_key_sp = (next_key_sp < W'(`PLSC_KEY_STEP)) ? '0
                    : next_key_sp - W'(`PLSC_KEY_STEP);
      end
    end
    next_rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `PLSC_OFS_CTRL:      next_rdata = {29'h0, ctrl};
        `PLSC_OFS_SOURCE:    next_rdata = {29'h0, src_reg};
        `PLSC_OFS_PRESET1:   next_rdata = {16'h0, preset1};
        `PLSC_OFS_PRESET2:   next_rdata = {16'h0, preset2};
        `PLSC_OFS_PRESET4:   next_rdata = {16'h0, preset4};
        `PLSC_OFS_KP:        next_rdata = {16'h0, kp};
        `PLSC_OFS_KI:        next_rdata = {16'h0, ki};
        `PLSC_OFS_KD:        next_rdata = {16'h0, kd};
        `PLSC_OFS_RAMP:      next_rdata = {16'h0, ramp_time};
        `PLSC_OFS_KEYPAD_SP: next_rdata = 32'(key_sp);
        `PLSC_OFS_STATUS:    next_rdata = {30'h0, conflict, o_loop_active};
        `PLSC_OFS_SPEED:     next_rdata = 32'(o_speed_cmd);
        `PLSC_OFS_SETPOINT:  next_rdata = 32'(sp_ramped);
        `PLSC_OFS_FEEDBACK:  next_rdata = 32'(fb_val);
        default:             next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl      <= `PLSC_RST_CTRL;
      src_reg   <= `PLSC_RST_SOURCE;
      preset1   <= `PLSC_RST_PRESET;
      preset2   <= `PLSC_RST_PRESET;
      preset4   <= `PLSC_RST_PRESET;
      kp        <= `PLSC_RST_KP;
      ki        <= `PLSC_RST_KI;
      kd        <= `PLSC_RST_KD;
      ramp_time <= `PLSC_RST_RAMP;
      key_sp    <= W'(`PLSC_RST_KSP);
      o_rdata   <= 32'h0;
    end else if (i_ce) begin
      ctrl      <= next_ctrl;
      src_reg   <= next_src;
      preset1   <= next_p1;
      preset2   <= next_p2;
      preset4   <= next_p4;
      kp        <= next_kp;
      ki        <= next_ki;
      kd        <= next_kd;
      ramp_time <= next_ramp;
      key_sp    <= next_key_sp;
      o_rdata   <= next_rdata;
    end
  end

  // ==================================================
  // Setpoint ramp
  plsc_ramp #(.W(W), .CYC_PER_TENTH(TENTH_CYCLES)) u_ramp (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_target    (sp_target),
    .i_ramp_time (ramp_time),
    .o_value     (sp_ramped)
  );

  // ==================================================
  // Control loop, updated once per sample period
  logic [31:0]          tick_cnt, next_tick_cnt;
  logic signed [SW-1:0] integ, next_integ;
  logic signed [SW-1:0] err_prev, next_err_prev;
  logic [W-1:0]         next_speed;
  logic                 next_active;
  logic signed [SW-1:0] err, p_term, i_term, d_term, sum, integ_sum;

  always_comb begin
    next_tick_cnt = (tick_cnt == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
    next_integ    = integ;
    next_err_prev = err_prev;
    next_speed    = o_speed_cmd;
    next_active   = loop_en;
    if (ctrl[`PLSC_CTRL_REVERSE]) begin
      err = SW'(fb_val) - SW'(sp_ramped);
    end else begin
      err = SW'(sp_ramped) - SW'(fb_val);
    end
    p_term    = SW'(PW'($signed({1'b0, kp}) * $signed(err[W:0])) >>> 8);
    integ_sum = integ + SW'(PW'($signed({1'b0, ki}) * $signed(err[W:0])));
    if (integ_sum > ACC_LIM) begin
      integ_sum = ACC_LIM;
    end else if (integ_sum < -ACC_LIM) begin
      integ_sum = -ACC_LIM;
    end
    i_term = integ_sum >>> 16;
    d_term = SW'(PW'($signed({1'b0, kd}) * $signed(err[W+1:0] - err_prev[W+1:0])));
    sum    = p_term + i_term + d_term;
    if (!loop_en) begin
      next_integ    = '0;
      next_err_prev = '0;
      next_speed    = '0;
    end else if (tick_cnt == 32'h0) begin
      next_integ    = integ_sum;
      next_err_prev = err;
      if (sum < 0) begin
        next_speed = '0;
      end else if (sum > SW'(FULL)) begin
        next_speed = FULL;
      end else begin
        next_speed = sum[W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt      <= 32'h0;
      integ         <= '0;
      err_prev      <= '0;
      o_speed_cmd   <= '0;
      o_loop_active <= 1'b0;
    end else if (i_ce) begin
      tick_cnt      <= next_tick_cnt;
      integ         <= next_integ;
      err_prev      <= next_err_prev;
      o_speed_cmd   <= next_speed;
      o_loop_active <= next_active;
    end
  end

  // ==================================================
  // Operator display
  plsc_pkg::plsc_disp_t disp, next_disp;
  logic [31:0]          flash_cnt, next_flash_cnt;
  logic                 next_is_freq;
  logic [15:0]          next_status_value;
  logic [15:0]          next_disp_value;

  always_comb begin
    next_disp      = disp;
    next_flash_cnt = (flash_cnt != 32'h0) ? flash_cnt - 32'h1 : 32'h0;
    if (ctrl[`PLSC_CTRL_LOOP_EN] && enter_press) begin
      case (disp)
        plsc_pkg::PLSC_DISP_LOAD:  next_disp = plsc_pkg::PLSC_DISP_VOLTS;
        plsc_pkg::PLSC_DISP_VOLTS: begin
          next_disp      = plsc_pkg::PLSC_DISP_FEEDBACK;
          next_flash_cnt = 32'(FLASH_CYCLES);
        end
        default: begin
          next_disp      = plsc_pkg::PLSC_DISP_LOAD;
          next_flash_cnt = 32'h0;
        end
      endcase
    end
    next_is_freq      = ctrl[`PLSC_CTRL_LOOP_EN];
    next_status_value = ctrl[`PLSC_CTRL_LOOP_EN] ? i_out_freq : 16'h0;
    case (next_disp)
      plsc_pkg::PLSC_DISP_LOAD:  next_disp_value = i_load_pct;
      plsc_pkg::PLSC_DISP_VOLTS: next_disp_value = i_motor_volts;
      default:                   next_disp_value = (next_flash_cnt != 32'h0) ? 16'h0
                                                 : 16'(fb_val);
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      disp               <= plsc_pkg::PLSC_DISP_LOAD;
      flash_cnt          <= 32'h0;
      o_status_is_freq   <= 1'b0;
      o_status_value     <= 16'h0;
      o_disp_field       <= 2'h0;
      o_disp_flash_label <= 1'b0;
      o_disp_value       <= 16'h0;
    end else if (i_ce) begin
      disp               <= next_disp;
      flash_cnt          <= next_flash_cnt;
      o_status_is_freq   <= next_is_freq;
      o_status_value     <= next_status_value;
      o_disp_field       <= next_disp;
      o_disp_flash_label <= (next_flash_cnt != 32'h0);
      o_disp_value       <= next_disp_value;
    end
  end

endmodule
